// ---- rtl/evq_params.svh ----
`ifndef EVQ_PARAMS_SVH
`define EVQ_PARAMS_SVH

`define OFS_EVT_CTRL 12'h040
`define OFS_EVT_STAT 12'h044
`define OFS_EVT_ADDR 12'h048
`define OFS_TXQ_CTRL 12'h050

`define EVT_CTRL_RST 32'h0000_0400
`define TXQ_CTRL_RST 32'h0060_0480

`define F_PAYLOAD_LSB 29
`define F_DEPTH_LSB 24
`define F_RETRY_LSB 21
`define F_PRIO_LSB 16
`define B_FLUSH 10
`define B_REQ 9
`define B_STEP 8
`define B_IS_TX 7
`define B_STAMP 5
`define B_OVF 3
`define B_RETRIES_IE 4
`define B_QEMPTY_IE 2
`define B_QNFULL_IE 0

`define OBJ_BYTES_PLAIN 32'h0000_000C
`define OBJ_BYTES_STAMP 32'h0000_0010

`endif

// ---- rtl/evq_pkg.sv ----
package evq_pkg;
    typedef logic [4:0] depth_sel_t;
    typedef logic [5:0] count_t;
    typedef logic [31:0] word_t;
    typedef enum logic [1:0]
    {
        RETRY_NONE = 2'h0,
        RETRY_THREE = 2'h1,
        RETRY_ALWAYS = 2'h2
    } retry_mode_t;
endpackage : evq_pkg

// ---- rtl/ring_ptr_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface ring_ptr_if;
    import evq_pkg::*;
    logic flush;
    logic push;
    logic pop;
    depth_sel_t depth_sel;
    count_t count;
    logic [4:0] head;
    logic [4:0] tail;
    logic overflow;
    modport owner (output flush, push, pop, depth_sel, input count, head, tail, overflow);
    modport tracker (input flush, push, pop, depth_sel, output count, head, tail, overflow);
endinterface : ring_ptr_if
`default_nettype wire

// ---- rtl/ring_ptr_tracker.sv ----
`timescale 1ns/1ps
`default_nettype none
module ring_ptr_tracker
(
    input wire logic clk,
    input wire logic nrst,
    ring_ptr_if.tracker rp
);
    import evq_pkg::*;

    count_t count_reg, count_next;
    logic [4:0] head_reg, head_next;
    logic [4:0] tail_reg, tail_next;
    logic ovf_reg, ovf_next;
    logic full, do_push, do_pop;

    function automatic logic [4:0] wrap_inc(input logic [4:0] p, input depth_sel_t last);
        wrap_inc = (p == last) ? 5'h00 : p + 5'h01;
    endfunction : wrap_inc

    always_comb
    begin
        full = (count_reg == ({1'b0, rp.depth_sel} + 6'h01));
        do_push = rp.push && !full;
        do_pop = rp.pop && (count_reg != 6'h00);
        count_next = count_reg;
        head_next = head_reg;
        tail_next = tail_reg;
        ovf_next = rp.push && full;
        if (do_push)
        begin
            head_next = wrap_inc(head_reg, rp.depth_sel);
        end
        if (do_pop)
        begin
            tail_next = wrap_inc(tail_reg, rp.depth_sel);
        end
        if (do_push && !do_pop)
        begin
            count_next = count_reg + 6'h01;
        end
        else if (do_pop && !do_push)
        begin
            count_next = count_reg - 6'h01;
        end
        if (rp.flush)
        begin
            count_next = 6'h00;
            head_next = 5'h00;
            tail_next = 5'h00;
            ovf_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count_reg <= 6'h00;
            head_reg <= 5'h00;
            tail_reg <= 5'h00;
            ovf_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            head_reg <= head_next;
            tail_reg <= tail_next;
            ovf_reg <= ovf_next;
        end
    end

    assign rp.count = count_reg;
    assign rp.head = head_reg;
    assign rp.tail = tail_reg;
    assign rp.overflow = ovf_reg;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_full_drops_event: assert property (
        (rp.push && full && !rp.flush && !rp.pop) |=> ($stable(head_reg) && ovf_reg))
        else $error("event accepted while buffer full");
    chk_step_one_slot: assert property (
        (rp.pop && !rp.push && !rp.flush && count_reg != 6'h00)
        |=> (count_reg == $past(count_reg) - 6'h01))
        else $error("tail step did not remove exactly one object");
endmodule : ring_ptr_tracker
`default_nettype wire

// ---- rtl/tx_event_queue_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "evq_params.svh"
module tx_event_queue_ctrl
#(
    parameter logic [31:0] EVT_BASE_ADDR = 32'h0000_0400
)
(
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic CONFIG_MODE,
    input wire logic NORMAL_MODE,
    input wire logic RETRY_LIMIT_EN,
    input wire logic EVENT_PUSH,
    input wire logic QUEUE_ALL_SENT,
    input wire logic QUEUE_ABORTED,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [11:0] REG_ADDR,
    input wire logic [3:0] REG_BE,
    input wire evq_pkg::word_t REG_WDATA,
    output var evq_pkg::word_t REG_RDATA,
    output var evq_pkg::count_t EVENT_DEPTH,
    output var logic EVENT_STAMP_EN,
    output var logic [4:0] EVENT_HEAD_IDX,
    output var logic EVENT_IRQ,
    output var evq_pkg::count_t QUEUE_DEPTH,
    output var logic [6:0] QUEUE_SLOT_BYTES,
    output var logic [4:0] QUEUE_PRIORITY,
    output var evq_pkg::retry_mode_t QUEUE_RETRY_MODE,
    output var logic QUEUE_SEND_REQ,
    output var logic QUEUE_ABORT_REQ,
    output var logic [4:0] QUEUE_HEAD_IDX,
    output var logic QUEUE_FLUSH
);
    import evq_pkg::*;

    ring_ptr_if evt_rp ();

    ring_ptr_tracker u_evt_ring
    (
        .clk(CORE_CLK),
        .nrst(NRST),
        .rp(evt_rp)
    );

    function automatic word_t merge_bytes(input word_t old, input word_t wd, input logic [3:0] be);
        word_t r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        merge_bytes = r;
    endfunction : merge_bytes

    function automatic count_t depth_of(input depth_sel_t sel);
        depth_of = {1'b0, sel} + 6'h01;
    endfunction : depth_of

    function automatic logic [6:0] payload_bytes(input logic [2:0] sel);
        case (sel)
            3'h0: payload_bytes = 7'h08;
            3'h1: payload_bytes = 7'h0C;
            3'h2: payload_bytes = 7'h10;
            3'h3: payload_bytes = 7'h14;
            3'h4: payload_bytes = 7'h18;
            3'h5: payload_bytes = 7'h20;
            3'h6: payload_bytes = 7'h30;
            default: payload_bytes = 7'h40;
        endcase
    endfunction : payload_bytes

    // Event buffer control state
    depth_sel_t evt_depth_reg, evt_depth_next;
    logic evt_stamp_reg, evt_stamp_next;
    logic [3:0] evt_ie_reg, evt_ie_next;
    logic evt_flush_reg, evt_flush_next;
    logic evt_ovf_reg, evt_ovf_next;
    logic evt_step;
    logic evt_full, evt_half, evt_ne;
    word_t evt_ctrl_rd, evt_stat_rd, evt_addr_rd, evt_wv;
    logic wr_evc, wr_evs;

    always_comb
    begin
        wr_evc = REG_WR && (REG_ADDR == `OFS_EVT_CTRL);
        wr_evs = REG_WR && (REG_ADDR == `OFS_EVT_STAT);
        evt_ctrl_rd = 32'h0000_0000;
        evt_ctrl_rd[`F_DEPTH_LSB +: 5] = evt_depth_reg;
        evt_ctrl_rd[`B_FLUSH] = evt_flush_reg;
        evt_ctrl_rd[`B_STAMP] = evt_stamp_reg;
        evt_ctrl_rd[3:0] = evt_ie_reg;
        evt_wv = merge_bytes(evt_ctrl_rd, REG_WDATA, REG_BE);
        evt_full = (evt_rp.count == depth_of(evt_depth_reg));
        evt_half = ({evt_rp.count, 1'b0} >= {1'b0, depth_of(evt_depth_reg)});
        evt_ne = (evt_rp.count != 6'h00);
        evt_stat_rd = {28'h000_0000, evt_ovf_reg, evt_full, evt_half, evt_ne};
        // tail address; stamped objects are larger
        evt_addr_rd = EVT_BASE_ADDR + {27'h000_0000, evt_rp.tail}
            * (evt_stamp_reg ? `OBJ_BYTES_STAMP : `OBJ_BYTES_PLAIN);
        evt_depth_next = evt_depth_reg;
        evt_stamp_next = evt_stamp_reg;
        evt_ie_next = evt_ie_reg;
        if (wr_evc && CONFIG_MODE)
        begin
            evt_depth_next = evt_wv[`F_DEPTH_LSB +: 5];
            evt_stamp_next = evt_wv[`B_STAMP];
        end
        if (wr_evc)
        begin
            evt_ie_next = evt_wv[3:0];
        end
        evt_flush_next = wr_evc && evt_wv[`B_FLUSH] && !evt_flush_reg;
        // step is a pulse, never stored
        evt_step = wr_evc && evt_wv[`B_STEP];
        // sticky, set wins over software clear
        evt_ovf_next = evt_rp.overflow
            || (evt_ovf_reg && !(wr_evs && REG_BE[0] && !REG_WDATA[`B_OVF]));
    end

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            evt_depth_reg <= 5'(`EVT_CTRL_RST >> `F_DEPTH_LSB);
            evt_stamp_reg <= 1'(`EVT_CTRL_RST >> `B_STAMP);
            evt_ie_reg <= 4'h0;
            evt_flush_reg <= 1'b1;
            evt_ovf_reg <= 1'b0;
        end
        else
        begin
            evt_depth_reg <= evt_depth_next;
            evt_stamp_reg <= evt_stamp_next;
            evt_ie_reg <= evt_ie_next;
            evt_flush_reg <= evt_flush_next;
            evt_ovf_reg <= evt_ovf_next;
        end
    end

    assign evt_rp.flush = evt_flush_reg;
    assign evt_rp.push = EVENT_PUSH;
    assign evt_rp.pop = evt_step;
    assign evt_rp.depth_sel = evt_depth_reg;

    // Transmit queue control state
    logic [2:0] q_pay_reg, q_pay_next;
    depth_sel_t q_depth_reg, q_depth_next;
    logic [1:0] q_retry_reg, q_retry_next;
    logic [4:0] q_prio_reg, q_prio_next;
    logic q_flush_reg, q_flush_next;
    logic q_req_reg, q_req_next;
    logic [2:0] q_ie_reg, q_ie_next;
    logic [4:0] q_head_reg, q_head_next;
    logic q_abort;
    word_t q_ctrl_rd, q_wv;
    logic wr_q;

    always_comb
    begin
        wr_q = REG_WR && (REG_ADDR == `OFS_TXQ_CTRL);
        q_ctrl_rd = 32'h0000_0000;
        q_ctrl_rd[`F_PAYLOAD_LSB +: 3] = q_pay_reg;
        q_ctrl_rd[`F_DEPTH_LSB +: 5] = q_depth_reg;
        q_ctrl_rd[`F_RETRY_LSB +: 2] = q_retry_reg;
        q_ctrl_rd[`F_PRIO_LSB +: 5] = q_prio_reg;
        q_ctrl_rd[`B_FLUSH] = q_flush_reg;
        q_ctrl_rd[`B_REQ] = q_req_reg;
        q_ctrl_rd[`B_IS_TX] = 1'b1;
        q_ctrl_rd[`B_RETRIES_IE] = q_ie_reg[2];
        q_ctrl_rd[`B_QEMPTY_IE] = q_ie_reg[1];
        q_ctrl_rd[`B_QNFULL_IE] = q_ie_reg[0];
        q_wv = merge_bytes(q_ctrl_rd, REG_WDATA, REG_BE);
        q_pay_next = q_pay_reg;
        q_depth_next = q_depth_reg;
        q_retry_next = q_retry_reg;
        q_prio_next = q_prio_reg;
        q_ie_next = q_ie_reg;
        q_head_next = q_head_reg;
        if (wr_q && CONFIG_MODE)
        begin
            q_pay_next = q_wv[`F_PAYLOAD_LSB +: 3];
            q_depth_next = q_wv[`F_DEPTH_LSB +: 5];
            q_retry_next = q_wv[`F_RETRY_LSB +: 2];
            q_prio_next = q_wv[`F_PRIO_LSB +: 5];
        end
        if (wr_q)
        begin
            q_ie_next = {q_wv[`B_RETRIES_IE], q_wv[`B_QEMPTY_IE], q_wv[`B_QNFULL_IE]};
        end
        // held in configuration, released in normal mode
        if (CONFIG_MODE)
        begin
            q_flush_next = 1'b1;
        end
        else if (NORMAL_MODE)
        begin
            q_flush_next = 1'b0;
        end
        else
        begin
            q_flush_next = q_flush_reg || (wr_q && q_wv[`B_FLUSH]);
        end
        // software clear of a set request asks for abort
        q_abort = wr_q && REG_BE[1] && !REG_WDATA[`B_REQ] && q_req_reg && !q_flush_reg;
        q_req_next = q_req_reg;
        if (QUEUE_ALL_SENT || QUEUE_ABORTED || q_abort)
        begin
            q_req_next = 1'b0;
        end
        // set wins over a hardware clear
        // Only a written one sets, so a byte-0 write cannot revive a cleared request
        if (wr_q && REG_BE[1] && REG_WDATA[`B_REQ] && !q_flush_reg)
        begin
            q_req_next = 1'b1;
        end
        if (wr_q && q_wv[`B_STEP])
        begin
            q_head_next = (q_head_reg == q_depth_reg) ? 5'h00 : q_head_reg + 5'h01;
        end
        // queue reset clears request and head
        if (q_flush_reg)
        begin
            q_req_next = 1'b0;
            q_head_next = 5'h00;
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            q_pay_reg <= 3'(`TXQ_CTRL_RST >> `F_PAYLOAD_LSB);
            q_depth_reg <= 5'(`TXQ_CTRL_RST >> `F_DEPTH_LSB);
            q_retry_reg <= 2'(`TXQ_CTRL_RST >> `F_RETRY_LSB);
            q_prio_reg <= 5'(`TXQ_CTRL_RST >> `F_PRIO_LSB);
            q_flush_reg <= 1'b1;
            q_req_reg <= 1'b0;
            q_ie_reg <= 3'h0;
            q_head_reg <= 5'h00;
        end
        else
        begin
            q_pay_reg <= q_pay_next;
            q_depth_reg <= q_depth_next;
            q_retry_reg <= q_retry_next;
            q_prio_reg <= q_prio_next;
            q_flush_reg <= q_flush_next;
            q_req_reg <= q_req_next;
            q_ie_reg <= q_ie_next;
            q_head_reg <= q_head_next;
        end
    end

    // Registered outputs, so every pin comes straight from a flop
    word_t rdata_next;
    logic irq_next;
    retry_mode_t retry_next;

    always_comb
    begin
        rdata_next = REG_RDATA;
        if (REG_RD)
        begin
            // Unmapped offsets answer zero
            case (REG_ADDR)
                `OFS_EVT_CTRL: rdata_next = evt_ctrl_rd;
                `OFS_EVT_STAT: rdata_next = evt_stat_rd;
                `OFS_EVT_ADDR: rdata_next = evt_addr_rd;
                `OFS_TXQ_CTRL: rdata_next = q_ctrl_rd;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        irq_next = |({evt_ovf_reg, evt_full, evt_half, evt_ne} & evt_ie_reg);
        // without global limit, retries never stop
        if (!RETRY_LIMIT_EN || q_retry_reg[1])
        begin
            retry_next = RETRY_ALWAYS;
        end
        else if (q_retry_reg[0])
        begin
            retry_next = RETRY_THREE;
        end
        else
        begin
            retry_next = RETRY_NONE;
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            REG_RDATA <= 32'h0000_0000;
            EVENT_DEPTH <= 6'h01;
            EVENT_IRQ <= 1'b0;
            QUEUE_DEPTH <= 6'h01;
            QUEUE_SLOT_BYTES <= 7'h08;
            QUEUE_RETRY_MODE <= RETRY_ALWAYS;
            QUEUE_ABORT_REQ <= 1'b0;
        end
        else
        begin
            REG_RDATA <= rdata_next;
            EVENT_DEPTH <= depth_of(evt_depth_reg);
            EVENT_IRQ <= irq_next;
            QUEUE_DEPTH <= depth_of(q_depth_reg);
            QUEUE_SLOT_BYTES <= payload_bytes(q_pay_reg);
            QUEUE_RETRY_MODE <= retry_next;
            QUEUE_ABORT_REQ <= q_abort;
        end
    end

    // stamp enable to the event writer
    assign EVENT_STAMP_EN = evt_stamp_reg;
    assign EVENT_HEAD_IDX = evt_rp.head;
    assign QUEUE_PRIORITY = q_prio_reg;
    assign QUEUE_SEND_REQ = q_req_reg;
    assign QUEUE_HEAD_IDX = q_head_reg;
    assign QUEUE_FLUSH = q_flush_reg;

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    sequence s_flush_write;
        wr_evc && evt_wv[`B_FLUSH] && !evt_flush_reg;
    endsequence
    sequence s_flush_done;
        evt_flush_reg ##1 (!evt_flush_reg && evt_rp.count == 6'h00);
    endsequence

    chk_flush_self_clear: assert property (
        s_flush_write |=> s_flush_done)
        else $error("event flush did not empty and clear");
    chk_depth_locked: assert property (
        (!CONFIG_MODE) |=> $stable(evt_depth_reg) && $stable(q_prio_reg) && $stable(q_pay_reg))
        else $error("config field changed outside configuration");
    chk_depth_out: assert property (
        ##1 (EVENT_DEPTH == $past(evt_depth_reg) + 6'h01))
        else $error("event depth is not field plus one");
    chk_ovf_sticky: assert property (
        (evt_ovf_reg && !(wr_evs && REG_BE[0])) |=> evt_ovf_reg)
        else $error("overflow flag lost without clear");
    chk_full_flag: assert property (
        (EVENT_PUSH && !evt_full && !wr_evc && !evt_flush_reg
        && evt_rp.count == {1'b0, evt_depth_reg}) |=> evt_full)
        else $error("full flag low after last slot filled");
    chk_irq_gate: assert property (
        (evt_ie_reg == 4'h0) |=> !EVENT_IRQ)
        else $error("interrupt raised with all enables off");
    chk_nonempty_flag: assert property (
        (EVENT_PUSH && !evt_full && !evt_flush_reg) |=> evt_ne)
        else $error("not-empty flag low after accepted event");
    chk_qflush_config: assert property (
        CONFIG_MODE |=> q_flush_reg)
        else $error("queue flush not held in configuration");
    chk_qflush_normal: assert property (
        (NORMAL_MODE && !CONFIG_MODE) |=> !q_flush_reg)
        else $error("queue flush not released in normal mode");
    chk_req_done: assert property (
        (QUEUE_ALL_SENT && !(wr_q && REG_BE[1] && REG_WDATA[`B_REQ])) |=> !q_req_reg)
        else $error("send request not cleared when all sent");
    chk_abort_pulse: assert property (
        (q_req_reg && wr_q && REG_BE[1] && !REG_WDATA[`B_REQ] && !q_flush_reg)
        |=> QUEUE_ABORT_REQ ##1 !QUEUE_ABORT_REQ [*1])
        else $error("abort request missing or not a pulse");
endmodule : tx_event_queue_ctrl
`default_nettype wire

// ---- tb/host_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
(
    input wire logic clk,
    output var logic wr_en,
    output var logic rd_en,
    output var logic [11:0] addr,
    output var logic [3:0] be,
    output var logic [31:0] wdata,
    input wire logic [31:0] rdata
);
    initial
    begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 12'h000;
        be = 4'h0;
        wdata = 32'h0000_0000;
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge clk);
        #1;
        addr = a;
        wdata = d;
        be = b;
        wr_en = 1'b1;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        // Released data lines must not keep the old value
        wdata = ~d;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        #1;
        addr = a;
        rd_en = 1'b1;
        @(posedge clk);
        #1;
        rd_en = 1'b0;
        // Read data held until next read, so take it a cycle late
        @(posedge clk);
        #1;
        d = rdata;
    endtask : rd
endmodule : host_bus_model
`default_nettype wire

// ---- tb/tb_tx_event_queue_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "evq_params.svh"
module tb_tx_event_queue_ctrl;
    import evq_pkg::*;
    localparam word_t BASE = 32'h0000_0400;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cfg = 1'b1;
    logic nrm = 1'b0;
    logic rlim = 1'b1;
    logic push = 1'b0;
    logic sent = 1'b0;
    logic abrt = 1'b0;
    logic wr, rd;
    logic [11:0] addr;
    logic [3:0] be;
    word_t wdata, rdata, v, d;
    count_t ev_depth, q_depth;
    logic stamp, irq, q_req, q_abort, q_flush;
    logic [4:0] ev_head, q_head, q_prio;
    logic [6:0] q_bytes;
    retry_mode_t q_mode;
    int mismatches = 0;
    int checks = 0;
    int n, k;
    always #50 clk = ~clk;
    host_bus_model host_inst (.clk(clk), .wr_en(wr), .rd_en(rd), .addr(addr), .be(be),
        .wdata(wdata), .rdata(rdata));
    tx_event_queue_ctrl #(.EVT_BASE_ADDR(BASE)) tx_event_queue_ctrl_inst (.CORE_CLK(clk),
        .NRST(nrst), .CONFIG_MODE(cfg), .NORMAL_MODE(nrm), .RETRY_LIMIT_EN(rlim),
        .EVENT_PUSH(push), .QUEUE_ALL_SENT(sent), .QUEUE_ABORTED(abrt), .REG_WR(wr),
        .REG_RD(rd), .REG_ADDR(addr), .REG_BE(be), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .EVENT_DEPTH(ev_depth), .EVENT_STAMP_EN(stamp), .EVENT_HEAD_IDX(ev_head),
        .EVENT_IRQ(irq), .QUEUE_DEPTH(q_depth), .QUEUE_SLOT_BYTES(q_bytes),
        .QUEUE_PRIORITY(q_prio), .QUEUE_RETRY_MODE(q_mode), .QUEUE_SEND_REQ(q_req),
        .QUEUE_ABORT_REQ(q_abort), .QUEUE_HEAD_IDX(q_head), .QUEUE_FLUSH(q_flush));
    function automatic word_t slot_bytes(input logic [2:0] c);
        if (c < 3'h5) return 32'h0000_0008 + {27'h0, c, 2'h0};
        if (c == 3'h5) return 32'h0000_0020;
        return (c == 3'h6) ? 32'h0000_0030 : 32'h0000_0040;
    endfunction : slot_bytes
    function automatic word_t retry_of(input logic [1:0] c, input logic en);
        return (!en || c[1]) ? 32'h0000_0002 : {30'h0, c};
    endfunction : retry_of
    // Event buffer is four deep from the config write until the mid-run reset
    function automatic word_t status_of(input int c, input logic o);
        return {28'h0, o, c == 4, c >= 2, c != 0};
    endfunction : status_of
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic cmp_port(input word_t got, input word_t exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_port
    task automatic cmp_reg(input logic [11:0] a, input word_t exp);
        host_inst.rd(a, v);
        cmp_port(v, exp);
    endtask : cmp_reg
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : tick
    task automatic flush_evt();
        host_inst.wr(`OFS_EVT_CTRL, 32'h0000_0400, 4'h2);
        k = 0;
        v = 32'hFFFF_FFFF;
        while (v[`B_FLUSH] !== 1'b0 && k < 20)
        begin
            host_inst.rd(`OFS_EVT_CTRL, v);
            k++;
        end
        if (v[`B_FLUSH] !== 1'b0)
        begin
            mismatches++;
            $display("ERROR %0t: flush never finished", $time);
            report_and_stop();
        end
    endtask : flush_evt
    initial
    begin
        void'($urandom(32'hEA78));
        repeat (10) @(posedge clk);
        #1;
        nrst = 1'b1;
        cmp_reg(`OFS_EVT_CTRL, 32'h0000_0000);
        cmp_reg(`OFS_TXQ_CTRL, `TXQ_CTRL_RST);
        cmp_reg(12'h0F0, 32'h0000_0000);
        host_inst.wr(`OFS_EVT_CTRL, 32'hE3FF_F2FF, 4'hF);
        cmp_reg(`OFS_EVT_CTRL, 32'h0300_002F);
        cmp_port(ev_depth, 32'h0000_0004);
        cmp_port(stamp, 32'h0000_0001);
        $display("event config test done");
        for (int i = 0; i < 8; i++)
        begin
            d = (i == 0) ? 32'h0 : (i == 7) ? 32'h1F : $urandom_range(0, 31);
            v = $urandom;
            n = {i[2:0], d[4:0], 1'b0, i[1:0], v[4:0], 16'h0};
            host_inst.wr(`OFS_TXQ_CTRL, n, 4'hF);
            tick(1);
            cmp_port(q_bytes, slot_bytes(i[2:0]));
            cmp_port(q_mode, retry_of(i[1:0], 1'b1));
            cmp_port(q_prio, v[4:0]);
            cmp_port(q_depth, d + 1);
            cmp_reg(`OFS_TXQ_CTRL, n | 32'h0000_0480);
        end
        // Three-retry code, so the global enable really matters
        host_inst.wr(`OFS_TXQ_CTRL, 32'h0020_0000, 4'h4);
        rlim = 1'b0;
        tick(2);
        cmp_port(q_mode, 32'h0000_0002);
        rlim = 1'b1;
        tick(2);
        cmp_port(q_mode, 32'h0000_0001);
        cfg = 1'b0;
        nrm = 1'b1;
        tick(2);
        cmp_port(q_flush, 32'h0000_0000);
        $display("queue config test done");
        host_inst.wr(`OFS_EVT_CTRL, 32'h0000_000F, 4'hF);
        cmp_reg(`OFS_EVT_CTRL, 32'h0300_002F);
        host_inst.wr(`OFS_TXQ_CTRL, 32'h0000_0100, 4'h2);
        tick(1);
        cmp_port(q_head, 32'h0000_0001);
        for (int j = 0; j < 3; j++)
        begin
            host_inst.wr(`OFS_TXQ_CTRL, 32'h0000_0200, 4'h2);
            cmp_port(q_req, 32'h0000_0001);
            if (j == 2)
            begin
                host_inst.wr(`OFS_TXQ_CTRL, 32'h0000_0000, 4'h2);
                cmp_port(q_abort, 32'h0000_0001);
                cmp_port(q_req, 32'h0000_0000);
                tick(1);
                cmp_port(q_abort, 32'h0000_0000);
            end
            else
            begin
                sent = (j == 0);
                abrt = (j == 1);
                tick(1);
                sent = 1'b0;
                abrt = 1'b0;
                cmp_port(q_req, 32'h0000_0000);
            end
        end
        $display("queue request test done");
        for (int it = 0; it < 5; it++)
        begin
            flush_evt();
            host_inst.wr(`OFS_EVT_STAT, 32'h0000_0000, 4'h1);
            n = (it == 0) ? 5 : (it == 4) ? 3 : $urandom_range(0, 5);
            if (n > 0)
            begin
                push = 1'b1;
                tick(n);
                push = 1'b0;
            end
            cmp_reg(`OFS_EVT_STAT, status_of((n > 4) ? 4 : n, n > 4));
            cmp_port(ev_head, ((n > 4) ? 4 : n) % 4);
            cmp_port(irq, n > 0);
            cmp_reg(`OFS_EVT_ADDR, BASE);
            if (n > 0)
            begin
                host_inst.wr(`OFS_EVT_CTRL, 32'h0000_0100, 4'h2);
                cmp_reg(`OFS_EVT_ADDR, BASE + `OBJ_BYTES_STAMP);
                cmp_reg(`OFS_EVT_STAT, status_of(((n > 4) ? 4 : n) - 1, n > 4));
            end
            if (n > 4)
            begin
                host_inst.wr(`OFS_EVT_STAT, 32'h0000_0000, 4'h1);
                cmp_reg(`OFS_EVT_STAT, status_of(3, 1'b0));
            end
        end
        host_inst.wr(`OFS_EVT_CTRL, 32'h0000_0000, 4'h1);
        tick(2);
        cmp_port(irq, 32'h0000_0000);
        $display("event buffer test done");
        // Reset in mid-run, outside configuration
        nrst = 1'b0;
        tick(1);
        nrst = 1'b1;
        cmp_reg(`OFS_EVT_CTRL, 32'h0000_0000);
        cmp_reg(`OFS_TXQ_CTRL, 32'h0060_0080);
        cmp_port(ev_depth, 32'h0000_0001);
        cmp_port(stamp, 32'h0000_0000);
        $display("mid-run reset test done");
        report_and_stop();
    end
endmodule : tb_tx_event_queue_ctrl
`default_nettype wire
